//--- rtl/rais_core.sv
// The placing of the registers and register access over Wishbone were chosen for this implementation.
`timescale 1ns/1ns
// Behaviour
// - crystal option: power-on holds reset 4064 bus cycles after oscillator start
// - rc option: power-on holds reset 2 bus cycles after oscillator start
// - reset pin still low after power-on delay keeps reset until it rises
// - any reset clears prescaler, loads counter fffc, clears compare bits and enables
// - any reset clears directions, stack to 00ff, sets mask, fetches vector 1ffe
// - any reset clears external interrupt, wait and stop latches
// - pin restart outside stop adds a two bus cycle delay
// - pin release from stop applies the full 4064 bus cycle start-up timeout
// - reset sequence starts on first bus clock edge after pin rises
// - cleared enable blocks the request but its flag still sets
// - pending enabled interrupt taken at instruction end: stack, mask, vector; return restores only the stack pointer
// - vectors fixed: reset 1ffe, trap 1ffc, external 1ffa, timer 1ff8
// - trap vectors through 1ffc and ignores the mask bit
// - external request when mask clear and pin or enabled input port pin low
// - build option picks edge-and-level or edge-only for all external sources
// - level mode: line still low after service raises the next interrupt
// - latch clears at service entry; one further edge is latched for later
// - stop turns oscillator off until external interrupt or reset
// - wait stops processor clocks, timer runs; exits on reset or any interrupt
// - wait and stop exits use ordinary vectors with no exit indication
// - external interrupt under mask is latched and served once mask clears
// - interrupt entry pushes five bytes onto the stack
module rais_core
  import rais_pkg::*;
#(
  parameter bit          XTAL_OPT   = 1'b1,
  parameter bit          EDGE_ONLY  = 1'b0,
  parameter logic [5:0]  PORTA_OPT  = 6'h3f,
  parameter int unsigned XTAL_DELAY = XTAL_CLKS
) (
  // clock and power-on reset
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // external pins, active low
  input  wire logic              reset_n_i,
  input  wire logic              irq_n_i,
  input  wire logic [5:0]        port_a_n_i,
  // timer events, one-cycle pulses
  input  wire logic              cap_event_i,
  input  wire logic              cmp_event_i,
  input  wire logic              wrap_event_i,
  // processor events
  input  wire rais_pkg::rais_cpu_s cpu_i,
  // register bus
  input  wire rais_pkg::rais_wb_req_s wb_i,
  output rais_pkg::rais_wb_rsp_s wb_o,
  // processor control
  output logic                   cpu_reset_o,
  output logic                   osc_en_o,
  output logic                   cpu_clk_en_o,
  output logic                   timer_clk_en_o,
  output logic                   timer_init_o,
  output logic                   vector_load_o,
  output logic [12:0]            vector_o,
  output logic [12:0]            sp_o,
  output logic                   mask_o,
  output logic [5:0]             ddr_a_o,
  output logic [7:0]             ddr_c_o,
  output logic                   compare_output_bit_o,
  output logic                   compare_output_level_o
);

  ////////////////////////////////////////////////////////////////////////////
  // state record
  typedef struct packed {
    rais_state_e state;
    logic [13:0] cnt;
    logic        div;
    logic [1:0]  rst_sync;
    logic [1:0]  irq_sync;
    logic [11:0] pa_sync;
    logic        line_low_q;
    logic        ext_latch;
    logic        stop_wake;
    logic        mask;
    logic [12:0] sp;
    logic [2:0]  flags;
    logic [2:0]  armed;
    logic [2:0]  enables;
    logic        compare_output_level;
    logic        cmp_bit;
    logic [5:0]  ddra;
    logic [7:0]  ddrc;
    logic        ack;
    logic [31:0] rdata;
    logic        vload;
    logic [12:0] vec;
    logic        tinit;
  } rais_reg_s;

  rais_reg_s r;
  rais_reg_s next_r;

  ////////////////////////////////////////////////////////////////////////////
  // combinational helpers
  logic        pin_low;
  logic [5:0]  pa_low;
  logic        line_low;
  logic        fall;
  logic        ext_pend;
  logic        tim_pend;
  logic        bus_tick;
  logic        wb_hit;
  logic [13:0] por_len;

  // synchronised pins: second stage only
  assign pin_low  = ~r.rst_sync[1];
  assign pa_low   = ~r.pa_sync[11:6];
  // port pin needs option and input direction
  assign line_low = ~r.irq_sync[1] | (|(pa_low & PORTA_OPT & ~r.ddra));
  assign fall     = line_low & ~r.line_low_q;
  // level term dropped in edge-only build
  // line still low keeps request alive
  assign ext_pend = r.ext_latch | (~EDGE_ONLY & line_low);
  assign tim_pend = |(r.flags & r.enables);
  assign bus_tick = r.div;
  assign wb_hit   = wb_i.cyc & wb_i.stb & ~r.ack;
  assign por_len  = XTAL_OPT ? XTAL_DELAY[13:0] : RC_CLKS[13:0];

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    next_r          = r;
    next_r.vload    = 1'b0;
    next_r.tinit    = 1'b0;
    next_r.ack      = wb_hit;
    next_r.div      = ~r.div;
    next_r.rst_sync = {r.rst_sync[0], reset_n_i};
    next_r.irq_sync = {r.irq_sync[0], irq_n_i};
    next_r.pa_sync  = {r.pa_sync[5:0], port_a_n_i};
    next_r.line_low_q = line_low;

    if (fall) begin
      next_r.ext_latch = 1'b1;
    end

    // timer flags: software clear first, event wins over it
    if (wb_hit && wb_i.adr == OFS_ASSOC) begin
      next_r.flags = r.flags & ~r.armed;
      next_r.armed = 3'h0;
    end
    next_r.flags = next_r.flags | {wrap_event_i, cmp_event_i, cap_event_i};

    // register bus
    if (wb_hit) begin
      next_r.rdata = 32'h0;
      if (wb_i.adr == OFS_CTRL) begin
        next_r.rdata = {8'h0, r.ddrc, 2'h0, r.ddra, 3'h0, r.cmp_bit, r.compare_output_level, r.enables};
        if (wb_i.we && wb_i.sel[0]) begin
          next_r.enables = wb_i.dat[CTL_WRAP_EN:CTL_CAP_EN];
          next_r.compare_output_level    = wb_i.dat[CTL_COMPARE_OUTPUT_LEVEL];
        end
        if (wb_i.we && wb_i.sel[1]) begin
          next_r.ddra = wb_i.dat[CTL_DDRA_LSB +: 6];
        end
        if (wb_i.we && wb_i.sel[2]) begin
          next_r.ddrc = wb_i.dat[CTL_DDRC_LSB +: 8];
        end
      end else if (wb_i.adr == OFS_STATUS) begin
        next_r.rdata = {25'h0, r.state, r.ext_latch, r.flags};
        next_r.armed = r.armed | r.flags;
      end else if (wb_i.adr == OFS_CCR) begin
        next_r.rdata = {18'h0, r.sp, r.mask};
      end else begin
        next_r.rdata = 32'h0;
      end
    end

    // sequencer
    case (r.state)
      ST_POWER: begin
        if (r.cnt >= por_len - 14'h1) begin
          next_r.state = ST_HOLD;
          next_r.cnt   = 14'h0;
        end else begin
          next_r.cnt = r.cnt + 14'h1;
        end
      end
      ST_HOLD: begin
        // stay in reset while pin low
        // leave on first bus edge after rise
        if (!pin_low) begin
          next_r.state = ST_ALIGN;
        end
      end
      ST_ALIGN: begin
        if (pin_low) begin
          next_r.state = ST_HOLD;
        end else if (bus_tick) begin
          next_r.state = ST_DELAY;
          next_r.cnt   = 14'h0;
        end
      end
      ST_DELAY: begin
        // short delay, full timeout after stop
        if (pin_low) begin
          next_r.state = ST_HOLD;
        end else if (r.cnt >= (r.stop_wake ? XTAL_DELAY[13:0] : PIN_CLKS[13:0]) - 14'h1) begin
          next_r.state     = ST_RUN;
          next_r.stop_wake = 1'b0;
          next_r.vload     = 1'b1;
          next_r.vec       = VEC_RESET;
        end else begin
          next_r.cnt = r.cnt + 14'h1;
        end
      end
      ST_RUN: begin
        if (cpu_i.mask_set) begin
          next_r.mask = 1'b1;
        end
        if (cpu_i.mask_clr) begin
          next_r.mask = 1'b0;
        end
        if (cpu_i.ret) begin
          // return pops the five stacked bytes
          next_r.sp = SP_HIGH_BITS | 13'((r.sp[5:0] + 6'(IRQ_STACK_B)) & SP_LOW_MASK);
        end
        if (cpu_i.instr_end) begin
          if (cpu_i.trap) begin
            next_r.vec = VEC_TRAP;
          end else if (!r.mask && ext_pend) begin
            next_r.vec       = VEC_EXT;
            next_r.ext_latch = fall;
          end else if (!r.mask && tim_pend) begin
            next_r.vec = VEC_TIMER;
          end
          if (cpu_i.trap || (!r.mask && (ext_pend || tim_pend))) begin
            next_r.sp    = SP_HIGH_BITS | 13'((r.sp[5:0] - 6'(IRQ_STACK_B)) & SP_LOW_MASK);
            next_r.mask  = 1'b1;
            next_r.vload = 1'b1;
          end else if (cpu_i.stop) begin
            next_r.state = ST_STOP;
            next_r.mask  = 1'b0;
            // restart the oscillator timeout from zero on every stop entry
            next_r.cnt   = 14'h0;
          end else if (cpu_i.wait_cmd) begin
            next_r.state = ST_WAIT;
            next_r.mask  = 1'b0;
          end
        end
      end
      ST_WAIT: begin
        if (ext_pend || tim_pend) begin
          next_r.state = ST_RUN;
          next_r.vec   = ext_pend ? VEC_EXT : VEC_TIMER;
          next_r.ext_latch = ext_pend ? fall : r.ext_latch;
          next_r.sp    = SP_HIGH_BITS | 13'((r.sp[5:0] - 6'(IRQ_STACK_B)) & SP_LOW_MASK);
          next_r.mask  = 1'b1;
          next_r.vload = 1'b1;
        end
      end
      ST_STOP: begin
        // external request or pin reset wakes; restart oscillator timeout
        if (ext_pend) begin
          if (r.cnt >= XTAL_DELAY[13:0] - 14'h1) begin
            next_r.state     = ST_RUN;
            next_r.cnt       = 14'h0;
            next_r.vec       = VEC_EXT;
            next_r.ext_latch = fall;
            next_r.sp    = SP_HIGH_BITS | 13'((r.sp[5:0] - 6'(IRQ_STACK_B)) & SP_LOW_MASK);
            next_r.mask  = 1'b1;
            next_r.vload = 1'b1;
          end else begin
            next_r.cnt = r.cnt + 14'h1;
          end
        end
      end
      default: begin
        next_r.state = ST_HOLD;
      end
    endcase

    // pin low, sampled every clk_i cycle, forces reset outside power-on
    if (pin_low && r.state != ST_POWER) begin
      next_r.stop_wake = (r.state == ST_STOP) | r.stop_wake;
      next_r.state     = ST_HOLD;
      next_r.cnt       = 14'h0;
    end

    // reset effects held while in any reset state
    if (next_r.state == ST_POWER || next_r.state == ST_HOLD ||
        next_r.state == ST_ALIGN || next_r.state == ST_DELAY) begin
      next_r.tinit   = 1'b1;
      next_r.enables = 3'h0;
      next_r.compare_output_level    = 1'b0;
      next_r.cmp_bit = 1'b0;
      next_r.ddra    = 6'h0;
      next_r.ddrc    = 8'h0;
      next_r.sp      = SP_RESET;
      next_r.mask    = 1'b1;
      next_r.ext_latch = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register, power-on reset to constants
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r          <= '0;
      r.state    <= ST_POWER;
      r.rst_sync <= 2'h3;
      r.irq_sync <= 2'h3;
      r.pa_sync  <= 12'hfff;
      r.mask     <= 1'b1;
      r.sp       <= SP_RESET;
      r.vec      <= VEC_RESET;
      r.tinit    <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign wb_o.ack   = r.ack;
  assign wb_o.dat   = r.rdata;
  assign cpu_reset_o = (r.state == ST_POWER) | (r.state == ST_HOLD) |
                       (r.state == ST_ALIGN) | (r.state == ST_DELAY);
  // oscillator off in stop until wake request
  assign osc_en_o       = ~((r.state == ST_STOP) & ~ext_pend);
  assign cpu_clk_en_o   = (r.state == ST_RUN);
  assign timer_clk_en_o = (r.state != ST_STOP);
  assign timer_init_o   = r.tinit;
  assign vector_load_o  = r.vload;
  assign vector_o       = r.vec;
  assign sp_o           = r.sp;
  assign mask_o         = r.mask;
  assign ddr_a_o        = r.ddra;
  assign ddr_c_o        = r.ddrc;
  assign compare_output_bit_o   = r.cmp_bit;
  assign compare_output_level_o = r.compare_output_level;

endmodule : rais_core

//--- inc/rais_pkg.sv
package rais_pkg;

  // bus timing: one bus cycle is two clk_i cycles
  localparam int unsigned CLK_MHZ        = 250;
  localparam int unsigned OSC_PER_BUS    = 2;
  localparam int unsigned XTAL_BUS_CYC   = 4064;
  localparam int unsigned RC_BUS_CYC     = 2;
  localparam int unsigned PIN_BUS_CYC    = 2;
  localparam int unsigned XTAL_CLKS      = XTAL_BUS_CYC * OSC_PER_BUS;
  localparam int unsigned RC_CLKS        = RC_BUS_CYC * OSC_PER_BUS;
  localparam int unsigned PIN_CLKS       = PIN_BUS_CYC * OSC_PER_BUS;

  // register byte offsets
  localparam logic [3:0]  OFS_CTRL       = 4'h0;
  localparam logic [3:0]  OFS_STATUS     = 4'h4;
  localparam logic [3:0]  OFS_ASSOC      = 4'h8;
  localparam logic [3:0]  OFS_CCR        = 4'hc;

  // control field positions
  localparam int unsigned CTL_CAP_EN     = 0;
  localparam int unsigned CTL_CMP_EN     = 1;
  localparam int unsigned CTL_WRAP_EN    = 2;
  localparam int unsigned CTL_COMPARE_OUTPUT_LEVEL       = 3;
  localparam int unsigned CTL_DDRA_LSB   = 8;
  localparam int unsigned CTL_DDRC_LSB   = 16;

  // reset values and stack constants
  localparam logic [12:0] SP_RESET       = 13'h00ff;
  localparam logic [15:0] COUNTER_RESET  = 16'hfffc;
  localparam logic [5:0]  SP_LOW_MASK    = 6'h3f;
  localparam logic [12:0] SP_HIGH_BITS   = 13'h00c0;
  localparam logic [2:0]  IRQ_STACK_B    = 3'h5;

  // vectors (first byte of each pair)
  localparam logic [12:0] VEC_RESET      = 13'h1ffe;
  localparam logic [12:0] VEC_TRAP       = 13'h1ffc;
  localparam logic [12:0] VEC_EXT        = 13'h1ffa;
  localparam logic [12:0] VEC_TIMER      = 13'h1ff8;

  typedef enum logic [2:0] {
    ST_POWER  = 3'b000,
    ST_HOLD   = 3'b001,
    ST_ALIGN  = 3'b010,
    ST_DELAY  = 3'b011,
    ST_RUN    = 3'b100,
    ST_WAIT   = 3'b101,
    ST_STOP   = 3'b110
  } rais_state_e;

  // wishbone request and answer
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [3:0]  adr;
    logic [31:0] dat;
  } rais_wb_req_s;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } rais_wb_rsp_s;

  // processor-side events, one-cycle pulses
  typedef struct packed {
    logic instr_end;
    logic trap;
    logic stop;
    logic wait_cmd;
    logic ret;
    logic mask_set;
    logic mask_clr;
  } rais_cpu_s;

endpackage : rais_pkg

//--- verification/rais_properties.sv
`timescale 1ns/1ns
module rais_properties
  import rais_pkg::*;
(
  // clock and reset
  input wire logic                clk_i,
  input wire logic                rst_i,
  // pin and processor events
  input wire logic                reset_n_i,
  input wire rais_pkg::rais_cpu_s cpu_i,
  // control outputs
  input wire logic                cpu_reset_o,
  input wire logic                cpu_clk_en_o,
  input wire logic                timer_clk_en_o,
  input wire logic                timer_init_o,
  input wire logic                vector_load_o,
  input wire logic [12:0]         vector_o,
  input wire logic [12:0]         sp_o,
  input wire logic                mask_o,
  input wire logic [5:0]          ddr_a_o,
  input wire logic [7:0]          ddr_c_o,
  input wire logic                compare_output_level_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////
  // instruction end accepted while running
  sequence run_end;
    cpu_i.instr_end && cpu_clk_en_o;
  endsequence
  // checks on reset, vectoring and sleep entry
  por_state_a: assert property ($fell(rst_i) |-> cpu_reset_o && mask_o && sp_o == SP_RESET)
    else $error("power-on state wrong");
  reset_clear_a: assert property (cpu_reset_o [*2] |-> ddr_a_o == 6'h0 && ddr_c_o == 8'h0
    && !compare_output_level_o && timer_init_o) else $error("reset did not clear outputs");
  reset_vector_a: assert property ($fell(cpu_reset_o) |-> vector_load_o
    && vector_o == VEC_RESET && mask_o && sp_o == SP_RESET) else $error("bad reset fetch");
  // stack wraps inside its 64-byte window, so only the low six bits move
  entry_push_a: assert property (vector_load_o && vector_o != VEC_RESET
    |-> mask_o && sp_o[5:0] == 6'($past(sp_o[5:0]) - 6'h5)) else $error("entry stacking wrong");
  return_pop_a: assert property (cpu_i.ret && cpu_clk_en_o
    |=> sp_o[5:0] == 6'($past(sp_o[5:0]) + 6'h5)) else $error("return did not unstack");
  trap_vector_a: assert property (run_end ##0 cpu_i.trap |=> vector_load_o
    && vector_o == VEC_TRAP) else $error("trap not vectored");
  masked_hold_a: assert property (run_end ##0 (mask_o && !cpu_i.trap && !cpu_i.wait_cmd
    && !cpu_i.mask_clr) |=> !vector_load_o) else $error("masked request taken");
  pin_reset_a: assert property (!reset_n_i [*3] |=> cpu_reset_o)
    else $error("pin low without reset");
  stop_entry_a: assert property (run_end ##0 (cpu_i.stop && mask_o && !cpu_i.trap)
    |=> !cpu_clk_en_o && !timer_clk_en_o) else $error("stop did not halt clocks");
  wait_entry_a: assert property (run_end ##0 (cpu_i.wait_cmd && mask_o && !cpu_i.trap
    && !cpu_i.stop) |=> !cpu_clk_en_o && timer_clk_en_o) else $error("wait clocks wrong");
endmodule : rais_properties

//--- verification/rais_pins.sv
`timescale 1ns/1ns
module rais_pins (
  // clock
  input  wire logic clk_i,
  // pin levels, active low
  output logic       reset_n_o,
  output logic       irq_n_o,
  output logic [5:0] port_a_n_o
);
  // idle: reset released, pull-ups keep requests high
  initial begin
    reset_n_o = 1'b1;
    irq_n_o = 1'b1;
    port_a_n_o = 6'h3f;
  end
  task automatic reset_pulse(input int n);
    reset_n_o <= 1'b0;
    repeat ((n < 3) ? 3 : n) @(posedge clk_i);
    reset_n_o <= 1'b1;
    @(posedge clk_i);
  endtask : reset_pulse
  // drive request lines for n clocks, or leave them when n is zero
  task automatic request(input logic irq, input logic [5:0] port, input int n);
    irq_n_o <= irq;
    port_a_n_o <= port;
    if (n > 0) begin
      repeat (n) @(posedge clk_i);
      irq_n_o <= 1'b1;
      port_a_n_o <= 6'h3f;
      @(posedge clk_i);
    end
  endtask : request
endmodule : rais_pins

//--- verification/tb_reset_and_interrupt_sequencer.sv
`timescale 1ns/1ns
module tb_reset_and_interrupt_sequencer;
  import rais_pkg::*;
  localparam int unsigned XTAL_DLY = 40;
  localparam logic [6:0]  E_END = 7'h40, E_RET = 7'h04, E_SET = 7'h02, E_CLR = 7'h01;
  typedef struct packed {
    logic        we;
    logic [3:0]  adr;
    logic [31:0] wd, msk, exp;
  } rais_row_s;
  // register rows: reset values, then a write read back
  rais_row_s rows [3] = '{'{1'b0, OFS_CCR, 32'h0, 32'h3fff, 32'h1ff},
    '{1'b0, OFS_STATUS, 32'h0, 32'h7f, 32'h40},
    '{1'b1, OFS_CTRL, 32'ha5150f, 32'hff3f0f, 32'ha5150f}};
  logic         clk_i = 1'b0, rst_i = 1'b1, reset_n_i, irq_n_i;
  logic [5:0]   port_a_n_i, ddr_a_o;
  logic         cap_event_i = 1'b0, cmp_event_i = 1'b0, wrap_event_i = 1'b0;
  rais_cpu_s    cpu_i = '0;
  rais_wb_req_s wb_i = '0;
  rais_wb_rsp_s wb_o;
  logic         cpu_reset_o, osc_en_o, cpu_clk_en_o, timer_clk_en_o, timer_init_o;
  logic         vector_load_o, mask_o, compare_output_bit_o, compare_output_level_o;
  logic [12:0]  vector_o, sp_o;
  logic [7:0]   ddr_c_o;
  logic         edge_vload;
  logic [31:0]  q;
  int           failures = 0, cmp_count = 0, waited;
  ////////////////////////////////////////
  // clock and instances
  always #2 clk_i = ~clk_i;
  rais_pins i_rais_pins (.clk_i, .reset_n_o(reset_n_i), .irq_n_o(irq_n_i),
    .port_a_n_o(port_a_n_i));
  rais_core #(.XTAL_DELAY(XTAL_DLY)) i_rais_core (.clk_i, .rst_i, .reset_n_i, .irq_n_i,
    .port_a_n_i, .cap_event_i, .cmp_event_i, .wrap_event_i, .cpu_i, .wb_i, .wb_o,
    .cpu_reset_o, .osc_en_o, .cpu_clk_en_o, .timer_clk_en_o, .timer_init_o, .vector_load_o,
    .vector_o, .sp_o, .mask_o, .ddr_a_o, .ddr_c_o, .compare_output_bit_o,
    .compare_output_level_o);
  // second build with edge-only triggering, watched through its vector strobe
  rais_core #(.XTAL_DELAY(XTAL_DLY), .EDGE_ONLY(1'b1)) i_rais_core_edge (.clk_i, .rst_i,
    .reset_n_i, .irq_n_i, .port_a_n_i, .cap_event_i, .cmp_event_i, .wrap_event_i, .cpu_i,
    .wb_i, .wb_o(), .cpu_reset_o(), .osc_en_o(), .cpu_clk_en_o(), .timer_clk_en_o(),
    .timer_init_o(), .vector_load_o(edge_vload), .vector_o(), .sp_o(), .mask_o(),
    .ddr_a_o(), .ddr_c_o(), .compare_output_bit_o(), .compare_output_level_o());
  // verdict and compare helpers
  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : results
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // one classic bus cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
                    output logic [31:0] r);
    int n;
    n = 0;
    wb_i <= '{cyc:1'b1, stb:1'b1, we:w, sel:4'hf, adr:a, dat:d};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_o.ack !== 1'b1 && n < 20);
    if (n >= 20) begin
      failures++;
      results();
    end
    r = wb_o.dat;
    wb_i.cyc <= 1'b0;
    wb_i.stb <= 1'b0;
    @(posedge clk_i);
  endtask : wb
  // processor event and timer event pulses
  task automatic ev(input logic [6:0] v);
    cpu_i <= v;
    @(posedge clk_i);
    cpu_i <= '0;
    @(posedge clk_i);
  endtask : ev
  task automatic tpulse(input logic [2:0] t);
    {wrap_event_i, cmp_event_i, cap_event_i} <= t;
    @(posedge clk_i);
    {wrap_event_i, cmp_event_i, cap_event_i} <= 3'h0;
    @(posedge clk_i);
  endtask : tpulse
  // wait for a vector fetch; zero means none may come
  task automatic vec(input logic [12:0] e, input int lim);
    logic [12:0] got;
    got = '0;
    for (waited = 0; waited < lim; waited++) begin
      if (vector_load_o === 1'b1) begin
        got = vector_o;
        break;
      end
      @(posedge clk_i);
    end
    chk(32'(got), 32'(e), "vector");
    if (got === 13'h0 && e !== 13'h0) results();
  endtask : vec
  ////////////////////////////////////////
  // main sequence
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    vec(VEC_RESET, 400);
    chk(32'(waited >= XTAL_DLY), 32'h1, "power delay");
    foreach (rows[i]) begin
      if (rows[i].we) wb(1'b1, rows[i].adr, rows[i].wd, q);
      wb(1'b0, rows[i].adr, 32'h0, q);
      chk(q & rows[i].msk, rows[i].exp, "register row");
    end
    $display("register rows done");
    ev(E_CLR);
    i_rais_pins.request(1'b1, 6'h3e, 4);
    ev(E_END);
    vec(13'h0, 6);
    i_rais_pins.request(1'b1, 6'h3d, 4);
    ev(E_END);
    vec(VEC_EXT, 6);
    ev(E_RET);
    chk(32'(sp_o), 32'(SP_RESET), "stack");
    $display("port request test done");
    wb(1'b1, OFS_CTRL, 32'h0, q);
    tpulse(3'h1);
    wb(1'b0, OFS_STATUS, 32'h0, q);
    chk(q & 32'h7, 32'h1, "flag");
    ev(E_CLR);
    ev(E_END);
    vec(13'h0, 6);
    wb(1'b0, OFS_ASSOC, 32'h0, q);
    wb(1'b0, OFS_STATUS, 32'h0, q);
    chk(q & 32'h7, 32'h0, "flag clear");
    wb(1'b1, OFS_CTRL, 32'h2, q);
    tpulse(3'h2);
    ev(E_END);
    vec(VEC_TIMER, 6);
    ev(E_RET);
    $display("timer flag test done");
    wb(1'b1, OFS_CTRL, 32'h4, q);
    ev(E_SET);
    ev(E_END | 7'h08);
    chk({30'h0, cpu_clk_en_o, timer_clk_en_o}, 32'h1, "wait clocks");
    tpulse(3'h4);
    vec(VEC_TIMER, 8);
    ev(E_RET);
    wb(1'b1, OFS_CTRL, 32'h0, q);
    ev(E_SET);
    ev(E_END | 7'h10);
    chk({30'h0, osc_en_o, cpu_clk_en_o}, 32'h0, "stop clocks");
    i_rais_pins.request(1'b0, 6'h3f, 4);
    vec(VEC_EXT, 200);
    chk(32'(waited >= XTAL_DLY - 4), 32'h1, "stop wake delay");
    ev(E_RET);
    $display("wait and stop test done");
    ev(E_SET);
    i_rais_pins.request(1'b0, 6'h3f, 0);
    ev(E_END);
    vec(13'h0, 6);
    wb(1'b0, OFS_STATUS, 32'h0, q);
    chk(q & 32'h8, 32'h8, "latch");
    for (int it = 0; it < 2; it++) begin
      ev(E_CLR);
      ev(E_END);
      vec(VEC_EXT, 6);
      chk(32'(edge_vload), 32'(it == 0), "edge mode vector");
      ev(E_RET);
    end
    i_rais_pins.request(1'b1, 6'h3f, 0);
    ev(E_SET);
    ev(E_END | 7'h20);
    vec(VEC_TRAP, 6);
    $display("level and trap test done");
    wb(1'b1, OFS_CTRL, 32'ha5150f, q);
    i_rais_pins.reset_pulse(3);
    vec(VEC_RESET, 100);
    chk(32'(waited < XTAL_DLY), 32'h1, "pin delay");
    wb(1'b0, OFS_CTRL, 32'h0, q);
    chk(q & 32'hff3f0f, 32'h0, "ctrl reset");
    wb(1'b0, OFS_STATUS, 32'h0, q);
    chk(q & 32'h78, 32'h40, "latch reset");
    wb(1'b0, OFS_CCR, 32'h0, q);
    chk(q & 32'h3fff, 32'h1ff, "ccr reset");
    ev(E_END | 7'h10);
    i_rais_pins.reset_pulse(3);
    vec(VEC_RESET, 200);
    chk(32'(waited >= XTAL_DLY), 32'h1, "stop delay");
    $display("pin reset test done");
    results();
  end
endmodule : tb_reset_and_interrupt_sequencer
bind rais_core rais_properties i_rais_properties (.clk_i, .rst_i, .reset_n_i, .cpu_i,
  .cpu_reset_o, .cpu_clk_en_o, .timer_clk_en_o, .timer_init_o, .vector_load_o, .vector_o,
  .sp_o, .mask_o, .ddr_a_o, .ddr_c_o, .compare_output_level_o);
